/* File: rtl/mtcv_defs.svh */
// Register offsets, field positions, reset values of the trap block
// Assumes inclusion by bare name; APB byte addresses, 32-bit words
`ifndef MTCV_DEFS_SVH
`define MTCV_DEFS_SVH

`define MTCV_ADDR_W        8
`define MTCV_OFS_PEND_LO   8'h00
`define MTCV_OFS_PEND_HI   8'h04
`define MTCV_OFS_CAUSE_LO  8'h08
`define MTCV_OFS_CAUSE_HI  8'h0c
`define MTCV_OFS_TVEC_LO   8'h10
`define MTCV_OFS_TVEC_HI   8'h14
`define MTCV_OFS_EPC_LO    8'h18
`define MTCV_OFS_EPC_HI    8'h1c
`define MTCV_OFS_STATUS    8'h20

`define MTCV_BIT_SUP_SOFT  1
`define MTCV_BIT_MACH_SOFT 3
`define MTCV_BIT_SUP_TIMER 5
`define MTCV_BIT_MACH_TIMER 7
`define MTCV_BIT_SUP_EXT   9
`define MTCV_BIT_MACH_EXT  11
`define MTCV_BIT_LOCAL_LO  16
`define MTCV_BIT_LOCAL_HI  63
`define MTCV_BIT_IRQ_FLAG  63
`define MTCV_BIT_MIE       3
`define MTCV_BIT_PRIOR_EN  7

`define MTCV_RST_CAUSE     64'h0000_0000_0000_0000
`define MTCV_RST_BASE      62'h0
`define MTCV_RST_EPC       64'h0000_0000_0000_0000
`define MTCV_SYNC_STAGES   2
`define MTCV_VEC_SHIFT     2

`endif

/* File: rtl/mtcv_pkg.sv */
// Types shared by the machine trap block
// Assumes the defines header is compiled alongside
package mtcv_pkg;

   typedef enum logic [1:0] {
      mtcv_mode_direct   = 2'b00,
      mtcv_mode_vectored = 2'b01
   } mtcv_mode_type;

   typedef enum logic [5:0] {
      mtcv_exc_fetch_misaligned = 6'h00,
      mtcv_exc_fetch_fault      = 6'h01,
      mtcv_exc_illegal          = 6'h02,
      mtcv_exc_breakpoint       = 6'h03,
      mtcv_exc_load_misaligned  = 6'h04,
      mtcv_exc_load_fault       = 6'h05,
      mtcv_exc_store_misaligned = 6'h06,
      mtcv_exc_store_fault      = 6'h07,
      mtcv_exc_ecall_user       = 6'h08,
      mtcv_exc_ecall_sup        = 6'h09,
      mtcv_exc_ecall_mach       = 6'h0b,
      mtcv_exc_fetch_page       = 6'h0c,
      mtcv_exc_load_page        = 6'h0d,
      mtcv_exc_store_page       = 6'h0f
   } mtcv_exc_code_type;

   typedef struct packed {
      logic        valid;
      logic        interrupt;
      logic [5:0]  code;
      logic [63:0] pc;
   } mtcv_trap_req_type;

   typedef struct packed {
      logic        valid;
      logic [63:0] target;
   } mtcv_redirect_type;

endpackage

/* File: rtl/mtcv_sync.sv */
// Two-flop synchroniser for a group of level inputs
// Assumes inputs are asynchronous levels held for several cycles
`timescale 1ns/1ps
module mtcv_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_first;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_first <= '0;
         sync_out    <= '0;
      end else begin
         stage_first <= async_in;
         sync_out    <= stage_first;
      end
   end

endmodule

/* File: rtl/mtcv_trap_calc.sv */
// Handler address computation, registered
// Assumes base and mode are the vector register contents
`include "mtcv_defs.svh"
`timescale 1ns/1ps
module mtcv_trap_calc (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire mtcv_pkg::mtcv_trap_req_type trap,
   input  wire logic [63:2]                base,
   input  wire mtcv_pkg::mtcv_mode_type    mode,
   output mtcv_pkg::mtcv_redirect_type     redirect
);

   logic [63:0] base_addr;
   logic [63:0] offset;

   always_comb begin
      // Low two address bits are implied zero
      base_addr = {base, 2'b00};
      offset    = 64'h0000_0000_0000_0000;
      // Only interrupts are vectored
      if (mode == mtcv_pkg::mtcv_mode_vectored && trap.interrupt) begin
         offset = {56'h00_0000_0000_0000, trap.code, 2'b00};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         redirect <= '0;
      end else begin
         redirect.valid  <= trap.valid;
         if (trap.valid) begin
            redirect.target <= base_addr + offset;
         end
      end
   end

endmodule

/* File: rtl/mtcv_top.sv */
// Machine trap state of one hart: pending, cause, vector, epc, status
// Assumes an APB master on pclk; irq request lines are asynchronous
//
// Operation
// - Pending bit 1, supervisor software, is readable and writable
// - Pending bit 3, machine software, is read-only
// - Pending bit 5, supervisor timer, is readable and writable
// - Pending bit 7 shows only the hardware timer request, read-only
// - Pending bit 9, supervisor external, is readable and writable
// - Pending bit 11 shows the external controller request, read-only
// - Pending bits 16..63 show local interrupts 0..47, read-only
// - Every machine trap writes the cause register with its event code
// - Interrupt traps set cause bit 63; low bits hold pending position
// - Exception traps clear cause bit 63; low bits hold the code
// - Cause bits 62..0 hold the code, bit 63 the interrupt flag
// - Exception codes 0..15 as listed; 10 and 14 reserved
// - Direct mode sends every trap to the base address
// - Mode 0 direct, 1 vectored, two and above reserved
// - Vectored interrupts go to base plus four times code
// - Base sits in bits 63..2; low address bits read as zero
// - All machine external interrupts report code 11
// - Each local interrupt gets its own vectored slot
// - Trap copies enable into prior enable, then clears enable
// - Trap saves the current pc into the exception pc
//
// Local design decisions: register access over APB and the address map.
`include "mtcv_defs.svh"
`timescale 1ns/1ps
module mtcv_top (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [`MTCV_ADDR_W-1:0]    paddr,
   input  wire logic [31:0]                pwdata,
   input  wire logic [3:0]                 pstrb,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       mach_soft_irq_req,
   input  wire logic                       mach_timer_irq_req,
   input  wire logic                       mach_external_irq_req,
   input  wire logic [47:0]                local_irq_req,
   input  wire mtcv_pkg::mtcv_trap_req_type trap,
   input  wire logic                       mret_valid,
   output mtcv_pkg::mtcv_redirect_type     redirect,
   output logic      [63:0]                exception_pc,
   output logic      [63:0]                pending_flags,
   output logic                            mach_irq_enable,
   output logic                            machine_prior_irq_enable
);

   // Synchronised hardware requests
   logic [50:0] hw_req_sync;
   logic        mach_soft_irq_pending;
   logic        mach_timer_irq_pending;
   logic        mach_external_irq_pending;
   logic [47:0] local_irq_pending;
   logic        local_irq_pending_first;
   logic        local_irq_pending_last;

   // Software-owned pending bits
   logic        sup_soft_irq_pending;
   logic        sup_timer_irq_pending;
   logic        sup_external_irq_pending;

   // Architectural state
   logic [63:0]             trap_cause;
   logic [63:2]             vector_base;
   mtcv_pkg::mtcv_mode_type vector_mode;

   // Bus decode
   logic        access;
   logic        wr_en;
   logic        rd_take;
   logic        addr_hit;
   logic [31:0] read_word;
   logic [31:0] old_word;
   logic [31:0] new_word;
   logic [63:0] pend_view;

   function automatic logic [31:0] merge_bytes(
      input logic [31:0] old_val,
      input logic [31:0] wr_val,
      input logic [3:0]  strb
   );
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = wr_val[i*8 +: 8];
         end
      end
      return res;
   endfunction

   mtcv_sync #(
      .WIDTH (51)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({local_irq_req, mach_external_irq_req,
                  mach_timer_irq_req, mach_soft_irq_req}),
      .sync_out (hw_req_sync)
   );

   assign mach_soft_irq_pending     = hw_req_sync[0];
   assign mach_timer_irq_pending    = hw_req_sync[1];
   assign mach_external_irq_pending = hw_req_sync[2];
   assign local_irq_pending         = hw_req_sync[50:3];
   assign local_irq_pending_first   = local_irq_pending[0];
   assign local_irq_pending_last    = local_irq_pending[47];

   // Pending view; unlisted positions tie to zero
   always_comb begin
      pend_view = 64'h0000_0000_0000_0000;
      pend_view[`MTCV_BIT_SUP_SOFT]   = sup_soft_irq_pending;
      pend_view[`MTCV_BIT_MACH_SOFT]  = mach_soft_irq_pending;
      pend_view[`MTCV_BIT_SUP_TIMER]  = sup_timer_irq_pending;
      pend_view[`MTCV_BIT_MACH_TIMER] = mach_timer_irq_pending;
      pend_view[`MTCV_BIT_SUP_EXT]    = sup_external_irq_pending;
      pend_view[`MTCV_BIT_MACH_EXT]   = mach_external_irq_pending;
      pend_view[`MTCV_BIT_LOCAL_HI:`MTCV_BIT_LOCAL_LO] =
         {local_irq_pending_last, local_irq_pending[46:1],
          local_irq_pending_first};
   end

   // APB decode
   assign access   = psel & penable;
   assign wr_en    = access & pready & pwrite;
   assign rd_take  = access & ~pready;

   always_comb begin
      addr_hit  = 1'b1;
      read_word = 32'h0000_0000;
      case (paddr)
         `MTCV_OFS_PEND_LO:  read_word = pend_view[31:0];
         `MTCV_OFS_PEND_HI:  read_word = pend_view[63:32];
         `MTCV_OFS_CAUSE_LO: read_word = trap_cause[31:0];
         `MTCV_OFS_CAUSE_HI: read_word = trap_cause[63:32];
         `MTCV_OFS_TVEC_LO:  read_word = {vector_base[31:2], vector_mode};
         `MTCV_OFS_TVEC_HI:  read_word = vector_base[63:32];
         `MTCV_OFS_EPC_LO:   read_word = exception_pc[31:0];
         `MTCV_OFS_EPC_HI:   read_word = exception_pc[63:32];
         `MTCV_OFS_STATUS: begin
            read_word[`MTCV_BIT_MIE]      = mach_irq_enable;
            read_word[`MTCV_BIT_PRIOR_EN] = machine_prior_irq_enable;
         end
         default: addr_hit = 1'b0;
      endcase
   end

   assign old_word = read_word;
   assign new_word = merge_bytes(old_word, pwdata, pstrb);

   // One wait state, then the answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= rd_take;
         pslverr <= rd_take & ~addr_hit;
         if (rd_take && !pwrite && addr_hit) begin
            prdata <= read_word;
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Software-writable pending bits; read-only ones have no write path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sup_soft_irq_pending     <= 1'b0;
         sup_timer_irq_pending    <= 1'b0;
         sup_external_irq_pending <= 1'b0;
      end else if (wr_en && paddr == `MTCV_OFS_PEND_LO) begin
         sup_soft_irq_pending     <= new_word[`MTCV_BIT_SUP_SOFT];
         sup_timer_irq_pending    <= new_word[`MTCV_BIT_SUP_TIMER];
         sup_external_irq_pending <= new_word[`MTCV_BIT_SUP_EXT];
      end
   end

   // Registered pending image for the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_flags <= 64'h0000_0000_0000_0000;
      end else begin
         pending_flags <= pend_view;
      end
   end

   // Cause: trap capture wins over a software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_cause <= `MTCV_RST_CAUSE;
      end else if (trap.valid) begin
         trap_cause <= {trap.interrupt, 57'h0, trap.code};
      end else if (wr_en && paddr == `MTCV_OFS_CAUSE_LO) begin
         trap_cause[31:0] <= new_word;
      end else if (wr_en && paddr == `MTCV_OFS_CAUSE_HI) begin
         trap_cause[63:32] <= new_word;
      end
   end

   // Vector register; reserved mode values leave the mode unchanged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_base <= `MTCV_RST_BASE;
         vector_mode <= mtcv_pkg::mtcv_mode_direct;
      end else if (wr_en && paddr == `MTCV_OFS_TVEC_LO) begin
         vector_base[31:2] <= new_word[31:2];
         case (new_word[1:0])
            2'h0:    vector_mode <= mtcv_pkg::mtcv_mode_direct;
            2'h1:    vector_mode <= mtcv_pkg::mtcv_mode_vectored;
            default: vector_mode <= vector_mode;
         endcase
      end else if (wr_en && paddr == `MTCV_OFS_TVEC_HI) begin
         vector_base[63:32] <= new_word;
      end
   end

   // Exception pc: trap capture wins over a software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exception_pc <= `MTCV_RST_EPC;
      end else if (trap.valid) begin
         exception_pc <= trap.pc;
      end else if (wr_en && paddr == `MTCV_OFS_EPC_LO) begin
         exception_pc[31:0] <= new_word;
      end else if (wr_en && paddr == `MTCV_OFS_EPC_HI) begin
         exception_pc[63:32] <= new_word;
      end
   end

   // Enable and prior enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mach_irq_enable          <= 1'b0;
         machine_prior_irq_enable <= 1'b0;
      end else if (trap.valid) begin
         machine_prior_irq_enable <= mach_irq_enable;
         mach_irq_enable          <= 1'b0;
      end else if (mret_valid) begin
         mach_irq_enable          <= machine_prior_irq_enable;
         machine_prior_irq_enable <= 1'b1;
      end else if (wr_en && paddr == `MTCV_OFS_STATUS) begin
         mach_irq_enable          <= new_word[`MTCV_BIT_MIE];
         machine_prior_irq_enable <= new_word[`MTCV_BIT_PRIOR_EN];
      end
   end

   // Handler address for the taken trap
   mtcv_trap_calc u_calc (
      .pclk     (pclk),
      .presetn  (presetn),
      .trap     (trap),
      .base     (vector_base),
      .mode     (vector_mode),
      .redirect (redirect)
   );

endmodule

/* File: dv/mtcv_top_sva.sv */
// Port-level assertions for the machine trap block
// Assumes binding into mtcv_top; one clock, async active-low reset
`timescale 1ns/1ps
module mtcv_top_sva (
   input wire logic                         pclk,
   input wire logic                         presetn,
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pready,
   input wire logic                         mach_soft_irq_req,
   input wire logic                         mach_timer_irq_req,
   input wire logic                         mach_external_irq_req,
   input wire logic [47:0]                  local_irq_req,
   input wire mtcv_pkg::mtcv_trap_req_type  trap,
   input wire mtcv_pkg::mtcv_redirect_type  redirect,
   input wire logic [63:0]                  exception_pc,
   input wire logic [63:0]                  pending_flags,
   input wire logic                         mach_irq_enable,
   input wire logic                         machine_prior_irq_enable
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Edges since reset release, so $past never reaches into reset
   logic [2:0] up_cnt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_cnt <= 3'h0;
      end else if (up_cnt != 3'h7) begin
         up_cnt <= up_cnt + 3'h1;
      end
   end

   a_redir_follows: assert property (trap.valid |=> redirect.valid)
      else $error("no redirect after trap");
   a_redir_cause: assert property (redirect.valid |-> $past(trap.valid))
      else $error("redirect without trap");
   a_epc_saved: assert property (trap.valid |=> exception_pc == $past(trap.pc))
      else $error("exception pc not saved");
   a_enable_off: assert property (trap.valid |=> !mach_irq_enable)
      else $error("enable not cleared on trap");
   a_prior_copy: assert property (trap.valid ##1 1'b1 |->
         machine_prior_irq_enable == $past(mach_irq_enable))
      else $error("prior enable not copied");
   a_pend_rsvd: assert property ((pending_flags & 64'h0000_0000_0000_f555) == 64'h0)
      else $error("reserved pending bit set");
   a_timer_map: assert property (up_cnt == 3'h7 |->
         pending_flags[7] == $past(mach_timer_irq_req, 3))
      else $error("timer pending wrong");
   a_soft_ext: assert property (up_cnt == 3'h7 |->
         pending_flags[3] == $past(mach_soft_irq_req, 3)
         && pending_flags[11] == $past(mach_external_irq_req, 3))
      else $error("soft or external pending wrong");
   a_local_map: assert property (up_cnt == 3'h7 |->
         pending_flags[63:16] == $past(local_irq_req, 3))
      else $error("local pending wrong");
   a_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb wait state wrong");
endmodule

bind mtcv_top mtcv_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pready,
   .mach_soft_irq_req, .mach_timer_irq_req, .mach_external_irq_req, .local_irq_req,
   .trap, .redirect, .exception_pc, .pending_flags, .mach_irq_enable,
   .machine_prior_irq_enable);

/* File: dv/mtcv_top_tb.sv */
// Self-checking bench for the machine trap block
// Assumes APB with one wait state and redirect one edge after a trap
`timescale 1ns/1ps
`include "mtcv_defs.svh"
module mtcv_top_tb;
   logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]                  paddr;
   logic [31:0]                 pwdata, prdata;
   logic [3:0]                  pstrb;
   logic                        mach_soft_irq_req, mach_timer_irq_req, mach_external_irq_req;
   logic [47:0]                 local_irq_req;
   logic                        mret_valid;
   mtcv_pkg::mtcv_trap_req_type trap;
   mtcv_pkg::mtcv_redirect_type redirect;
   logic [32:0]                 apb_q[$];
   logic [63:0]                 tgt_q[$];
   logic [63:0]                 tb_base, v, e, p;
   logic                        tb_vec;
   logic [5:0]                  c;
   int                          k, n_errors, num_checks;

   mtcv_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .mach_soft_irq_req, .mach_timer_irq_req,
      .mach_external_irq_req, .local_irq_req, .trap, .mret_valid, .redirect,
      .exception_pc(), .pending_flags(), .mach_irq_enable(), .machine_prior_irq_enable());

   always #20 pclk = ~pclk;

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      if (n_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] x);
      int i;
      apb_q.push_back(x);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         n_errors++;
         final_report();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, {1'b0, x});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic trap_go(input logic irq, input logic [5:0] cd, input logic [63:0] pc);
      tgt_q.push_back((tb_vec && irq) ? tb_base + {56'h0, cd, 2'b00} : tb_base);
      trap <= {1'b1, irq, cd, pc};
      @(posedge pclk);
   endtask

   task automatic trap_end();
      trap.valid <= 1'b0;
      @(posedge pclk);
   endtask

   always @(posedge pclk) begin
      if (pready === 1'b1) chk({31'h0, pslverr, prdata}, {31'h0, apb_q.pop_front()});
      if (redirect.valid === 1'b1) chk(redirect.target, tgt_q.pop_front());
   end

   initial begin
      void'($urandom(22));
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
      {mach_soft_irq_req, mach_timer_irq_req, mach_external_irq_req} = 3'h0;
      local_irq_req = 48'h0;
      mret_valid = 1'b0;
      trap = '0;
      tb_base = 64'h0;
      tb_vec = 1'b0;
      n_errors = 0;
      num_checks = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(`MTCV_OFS_CAUSE_LO, 32'h0);
      rd(`MTCV_OFS_TVEC_LO, 32'h0);
      rd(`MTCV_OFS_STATUS, 32'h0);
      apb(1'b0, 8'h24, 32'h0, 33'h1_0000_0000);
      apb(1'b1, 8'h30, 32'hffff_ffff, 33'h1_0000_0000);
      for (k = 0; k < 6; k++) begin
         v = {$urandom, $urandom};
         mach_soft_irq_req <= v[0];
         mach_timer_irq_req <= v[1];
         mach_external_irq_req <= v[2];
         local_irq_req <= v[63:16];
         repeat (4) @(posedge pclk);
         e = {v[63:16], 4'h0, v[2], 3'h0, v[1], 3'h0, v[0], 3'h0};
         wr(`MTCV_OFS_PEND_LO, k[0] ? 32'hffff_ffff : 32'h0);
         rd(`MTCV_OFS_PEND_LO, e[31:0] | (k[0] ? 32'h222 : 32'h0));
         wr(`MTCV_OFS_PEND_HI, 32'hffff_ffff);
         rd(`MTCV_OFS_PEND_HI, e[63:32]);
      end
      wr(`MTCV_OFS_TVEC_HI, 32'h0000_0001);
      wr(`MTCV_OFS_TVEC_LO, 32'h0000_1000);
      tb_base = 64'h0000_0001_0000_1000;
      wr(`MTCV_OFS_TVEC_LO, 32'h0000_1003);
      rd(`MTCV_OFS_TVEC_LO, 32'h0000_1000);
      trap_go(1'b1, 6'h07, 64'h0);
      trap_end();
      for (k = 0; k < 16; k++) begin
         if (k != 10 && k != 14) begin
            p = {$urandom, $urandom};
            trap_go(1'b0, k[5:0], p);
            trap_end();
            rd(`MTCV_OFS_CAUSE_LO, k);
            rd(`MTCV_OFS_CAUSE_HI, 32'h0);
            rd(`MTCV_OFS_EPC_LO, p[31:0]);
            rd(`MTCV_OFS_EPC_HI, p[63:32]);
         end
      end
      wr(`MTCV_OFS_TVEC_LO, 32'h0000_1001);
      tb_vec = 1'b1;
      wr(`MTCV_OFS_TVEC_LO, 32'h0000_1002);
      rd(`MTCV_OFS_TVEC_LO, 32'h0000_1001);
      for (k = 0; k < 9; k++) begin
         c = (k < 6) ? 6'(2 * k + 1) : 6'(16 + $urandom_range(47));
         trap_go(1'b1, c, 64'h0);
         trap_end();
         rd(`MTCV_OFS_CAUSE_LO, {26'h0, c});
         rd(`MTCV_OFS_CAUSE_HI, 32'h8000_0000);
      end
      trap_go(1'b1, 6'h3f, 64'h0);
      trap_go(1'b0, 6'h02, 64'h0);
      trap_end();
      wr(`MTCV_OFS_STATUS, 32'h0000_0008);
      trap_go(1'b1, 6'h0b, 64'h0);
      trap_end();
      rd(`MTCV_OFS_STATUS, 32'h0000_0080);
      mret_valid <= 1'b1;
      @(posedge pclk);
      mret_valid <= 1'b0;
      rd(`MTCV_OFS_STATUS, 32'h0000_0088);
      wr(`MTCV_OFS_CAUSE_HI, 32'h8000_0001);
      rd(`MTCV_OFS_CAUSE_HI, 32'h8000_0001);
      pstrb <= 4'h1;
      wr(`MTCV_OFS_EPC_LO, 32'hffff_ffff);
      pstrb <= 4'hf;
      rd(`MTCV_OFS_EPC_LO, 32'h0000_00ff);
      repeat (3) @(posedge pclk);
      chk(64'(apb_q.size() + tgt_q.size()), 64'h0);
      final_report();
   end
endmodule
